// >>> core/sec_top.sv
// sec_top: hsync active-edge selection, clamp window source selection
// and slicer threshold setting, with a small strobe register port.
// assumes hsync, clamp and slicer result arrive asynchronously as pins,
// and that the register master never raises both strobes together.
module sec_top #(
  parameter int CNT_W = sec_pkg::CNT_W
) (
  input  wire logic                      mclk_in,
  input  wire logic                      rst_in,
  input  wire logic                      ce_in,
  input  wire logic                      hsync_in,
  input  wire logic                      clamp_in,
  input  wire logic                      embedded_sync_slicer_input_in,
  input  wire logic [sec_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [sec_pkg::DATA_W-1:0] wdata_in,
  input  wire logic                      wr_in,
  input  wire logic                      rd_in,
  output logic      [sec_pkg::DATA_W-1:0] rdata_out,
  output logic                           hsync_ref_out,
  output logic                           clamp_out,
  output logic      [sec_pkg::THR_W-1:0] slicer_thr_out,
  output logic                           embedded_sync_slicer_output_out
);

  // register fields are eight bits wide, so the counters must match
  if (CNT_W != sec_pkg::CNT_W) begin : g_cnt_w_check
    $error("sec_top: CNT_W must match the register width");
  end

  sec_pkg::sec_cfg_t   cfg, next_cfg;
  sec_pkg::sec_state_t int_state;
  logic [sec_pkg::DATA_W-1:0] next_rdata;
  logic hs_lvl, hs_prev, clamp_lvl, slice_lvl;
  logic hs_rise, hs_fall, hs_lead, hs_trail;
  logic int_active;
  logic next_hs_ref, next_clamp, ext_asserted;

  // pin synchronisers
  sec_sync #(.RST_VAL(1'b0)) u_hs_sync (
    .mclk_in   (mclk_in),
    .rst_in    (rst_in),
    .ce_in     (ce_in),
    .pin_in    (hsync_in),
    .level_out (hs_lvl)
  );

  sec_sync #(.RST_VAL(1'b0)) u_clamp_sync (
    .mclk_in   (mclk_in),
    .rst_in    (rst_in),
    .ce_in     (ce_in),
    .pin_in    (clamp_in),
    .level_out (clamp_lvl)
  );

  sec_sync #(.RST_VAL(1'b0)) u_slice_sync (
    .mclk_in   (mclk_in),
    .rst_in    (rst_in),
    .ce_in     (ce_in),
    .pin_in    (embedded_sync_slicer_input_in),
    .level_out (slice_lvl)
  );

  // edge detection on the filtered hsync level
  assign hs_rise = hs_lvl & ~hs_prev;
  assign hs_fall = ~hs_lvl & hs_prev;
  // R2: polarity picks the edge
  assign hs_lead  = cfg.hs_pol ? hs_rise : hs_fall;
  assign hs_trail = cfg.hs_pol ? hs_fall : hs_rise;

  // internal clamp counter, started on every trailing edge
  sec_clamp_gen #(.CNT_W(CNT_W)) u_clamp_gen (
    .mclk_in    (mclk_in),
    .rst_in     (rst_in),
    .ce_in      (ce_in),
    .start_in   (hs_trail),
    .dly_in     (cfg.clamp_dly),
    .dur_in     (cfg.clamp_dur),
    .active_out (int_active),
    .state_out  (int_state)
  );

  // register writes; unmapped and reserved bits are dropped, but a threshold write with reserved bits set is refused whole
  always_comb begin
    next_cfg = cfg;
    if (wr_in) begin
      case (addr_in)
        sec_pkg::REG_HSYNC_CTRL: begin
          next_cfg.hs_pol = wdata_in[sec_pkg::HS_POL_BIT];
        end
        // R3: clamp source select
        sec_pkg::REG_CLAMP_CTRL: begin
          next_cfg.clamp_ext = wdata_in[sec_pkg::CLAMP_EXT_BIT];
          next_cfg.clamp_pol = wdata_in[sec_pkg::CLAMP_POL_BIT];
        end
        sec_pkg::REG_CLAMP_DLY: begin
          next_cfg.clamp_dly = wdata_in[CNT_W-1:0];
        end
        sec_pkg::REG_CLAMP_DUR: begin
          next_cfg.clamp_dur = wdata_in[CNT_W-1:0];
        end
        // R9: out-of-range codes leave the old step
        sec_pkg::REG_SLICE_THR: begin
          if (wdata_in[sec_pkg::THR_W-1:0] >= sec_pkg::THR_MIN &&
              wdata_in[sec_pkg::THR_W-1:0] <= sec_pkg::THR_MAX &&
              wdata_in[sec_pkg::DATA_W-1:sec_pkg::THR_W] == '0) begin
            next_cfg.thr = wdata_in[sec_pkg::THR_W-1:0];
          end
        end
        default: begin
          next_cfg = cfg;
        end
      endcase
    end
  end

  // configuration registers
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      cfg.hs_pol    <= sec_pkg::HS_POL_RST;
      cfg.clamp_ext <= sec_pkg::CLAMP_EXT_RST;
      cfg.clamp_pol <= sec_pkg::CLAMP_POL_RST;
      cfg.clamp_dly <= sec_pkg::CLAMP_DLY_RST;
      cfg.clamp_dur <= sec_pkg::CLAMP_DUR_RST;
      cfg.thr       <= sec_pkg::THR_RST;
    end else if (ce_in) begin
      cfg <= next_cfg;
    end
  end

  // read mux; data stands only in the cycle after the strobe
  always_comb begin
    next_rdata = '0;
    if (rd_in) begin
      case (addr_in)
        sec_pkg::REG_HSYNC_CTRL: begin
          next_rdata[sec_pkg::HS_POL_BIT] = cfg.hs_pol;
        end
        sec_pkg::REG_CLAMP_CTRL: begin
          next_rdata[sec_pkg::CLAMP_EXT_BIT] = cfg.clamp_ext;
          next_rdata[sec_pkg::CLAMP_POL_BIT] = cfg.clamp_pol;
        end
        sec_pkg::REG_CLAMP_DLY: begin
          next_rdata[CNT_W-1:0] = cfg.clamp_dly;
        end
        sec_pkg::REG_CLAMP_DUR: begin
          next_rdata[CNT_W-1:0] = cfg.clamp_dur;
        end
        sec_pkg::REG_SLICE_THR: begin
          next_rdata[sec_pkg::THR_W-1:0] = cfg.thr;
        end
        sec_pkg::REG_STATUS: begin
          next_rdata[sec_pkg::ST_HSYNC_BIT] = hs_lvl;
          next_rdata[sec_pkg::ST_CLAMP_BIT] = clamp_out;
          next_rdata[sec_pkg::ST_INT_BIT]   = int_active;
        end
        default: begin
          next_rdata = '0;
        end
      endcase
    end
  end

  // video-side outputs
  always_comb begin
    // R5: polarity sets asserted level
    ext_asserted = (clamp_lvl == cfg.clamp_pol);
    // R1: leading edge only
    next_hs_ref = hs_lead;
    // R6: follow the external level
    if (cfg.clamp_ext) begin
      next_clamp = ext_asserted;
    end else begin
      // R4: pin ignored, counted window
      next_clamp = int_active;
    end
  end

  // output and edge-history flops; all frozen while ce_in is low
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      hs_prev                         <= 1'b0;
      rdata_out                       <= '0;
      hsync_ref_out                   <= 1'b0;
      clamp_out                       <= 1'b0;
      slicer_thr_out                  <= sec_pkg::THR_RST;
      embedded_sync_slicer_output_out <= 1'b0;
    end else if (ce_in) begin
      hs_prev        <= hs_lvl;
      rdata_out      <= next_rdata;
      hsync_ref_out  <= next_hs_ref;
      clamp_out      <= next_clamp;
      slicer_thr_out <= cfg.thr;
      // R10: no inversion
      embedded_sync_slicer_output_out <= slice_lvl;
    end
  end

  // checks on the block's own outputs, settings and clamp state

  property p_lead_only;
    @(posedge mclk_in) disable iff (rst_in || !ce_in)
      hs_trail |=> !hsync_ref_out;
  endproperty
  a_lead_only: assert property (p_lead_only) // R1
    else $error("hsync reference pulsed on a trailing edge");

  property p_pol_edge;
    @(posedge mclk_in) disable iff (rst_in || !ce_in)
      (hs_lvl && !hs_prev) |=> (hsync_ref_out == $past(cfg.hs_pol));
  endproperty
  a_pol_edge: assert property (p_pol_edge) // R2
    else $error("rising hsync edge handled against polarity");

  property p_ext_default;
    @(posedge mclk_in)
      rst_in |=> !cfg.clamp_ext;
  endproperty
  a_ext_default: assert property (p_ext_default) // R3
    else $error("clamp source select not zero after reset");

  property p_int_start;
    @(posedge mclk_in) disable iff (rst_in || !ce_in)
      (hs_trail && !cfg.clamp_ext && cfg.clamp_dly == '0 &&
       cfg.clamp_dur != '0) ##1 ce_in ##1 (ce_in && !cfg.clamp_ext)
        |-> clamp_out;
  endproperty
  a_int_start: assert property (p_int_start) // R4
    else $error("internal clamp did not open after zero delay");

  property p_ext_pol;
    @(posedge mclk_in) disable iff (rst_in || !ce_in)
      cfg.clamp_ext |=> (clamp_out == ($past(clamp_lvl) ==
                                       $past(cfg.clamp_pol)));
  endproperty
  a_ext_pol: assert property (p_ext_pol) // R5
    else $error("external clamp level not decoded by polarity");

  property p_ext_follow;
    @(posedge mclk_in) disable iff (rst_in || !ce_in)
      (cfg.clamp_ext && $stable(clamp_lvl) && $stable(cfg))
        |=> $stable(clamp_out);
  endproperty
  a_ext_follow: assert property (p_ext_follow) // R6
    else $error("clamp moved while external level held");

  property p_thr_range;
    @(posedge mclk_in) disable iff (rst_in)
      cfg.thr >= sec_pkg::THR_MIN && cfg.thr <= sec_pkg::THR_MAX;
  endproperty
  a_thr_range: assert property (p_thr_range) // R9
    else $error("slicer threshold outside 10 to 330 mV");

  property p_slice_pass;
    @(posedge mclk_in) disable iff (rst_in || !ce_in)
      ce_in |=> (embedded_sync_slicer_output_out == $past(slice_lvl));
  endproperty
  a_slice_pass: assert property (p_slice_pass) // R10
    else $error("slicer output inverted or stale");

  property p_restart;
    @(posedge mclk_in) disable iff (rst_in || !ce_in)
      (hs_trail && cfg.clamp_dly != '0) |=>
        (int_state == sec_pkg::SEC_WAIT);
  endproperty
  a_restart: assert property (p_restart) // R11
    else $error("clamp counter did not restart on trailing edge");

  property p_ref_pulse;
    @(posedge mclk_in) disable iff (rst_in || !ce_in)
      hsync_ref_out |=> !hsync_ref_out;
  endproperty
  a_ref_pulse: assert property (p_ref_pulse) // R1
    else $error("hsync reference wider than one cycle");

  property p_fall_edge;
    @(posedge mclk_in) disable iff (rst_in || !ce_in)
      (!hs_lvl && hs_prev) |=> (hsync_ref_out == !$past(cfg.hs_pol));
  endproperty
  a_fall_edge: assert property (p_fall_edge) // R2
    else $error("falling hsync edge handled against polarity");

  property p_int_used;
    @(posedge mclk_in) disable iff (rst_in || !ce_in)
      !cfg.clamp_ext |=> (clamp_out == $past(int_active));
  endproperty
  a_int_used: assert property (p_int_used) // R4
    else $error("clamp not taken from the counted window");

  property p_ext_on;
    @(posedge mclk_in) disable iff (rst_in || !ce_in)
      (cfg.clamp_ext && clamp_lvl == cfg.clamp_pol) |=> clamp_out;
  endproperty
  a_ext_on: assert property (p_ext_on) // R6
    else $error("clamp not raised while external level asserted");

  property p_thr_out;
    @(posedge mclk_in) disable iff (rst_in || !ce_in)
      ce_in |=> (slicer_thr_out == $past(cfg.thr));
  endproperty
  a_thr_out: assert property (p_thr_out) // R9
    else $error("slicer threshold output does not follow setting");

  property p_zero_dly;
    @(posedge mclk_in) disable iff (rst_in || !ce_in)
      (hs_trail && cfg.clamp_dly == '0 && cfg.clamp_dur != '0) |=>
        (int_state == sec_pkg::SEC_CLAMP);
  endproperty
  a_zero_dly: assert property (p_zero_dly) // R11
    else $error("zero delay did not open the window at once");

endmodule

// >>> core/sec_pkg.sv
// sec_pkg: register map, field positions, reset values and shared types
// for the sync edge selector and clamp window generator.
// assumes one pixel-rate clock and a plain strobe-based register port.
//
// Summary of operation
// R1: only the hsync leading edge marks a line
// R2: polarity bit zero falling, one rising edge
// R3: external clamp used only when select is one
// R4: otherwise count delay then duration from trailing
// R5: clamp polarity bit sets external asserted level
// R6: external mode clamps exactly while input asserted
// R7: source asserts clamp only during black level
// R8: unused clamp pin grounded, select left zero
// R9: slicer threshold 10 to 330 mV, reset 150
// R10: slicer result passed out without inversion
// R11: counters use pixel clocks, restart each line
package sec_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int CNT_W  = 8;
  localparam int THR_W  = 6;

  // register offsets
  localparam logic [7:0] REG_HSYNC_CTRL = 8'h0E;
  localparam logic [7:0] REG_CLAMP_CTRL = 8'h0F;
  localparam logic [7:0] REG_CLAMP_DLY  = 8'h10;
  localparam logic [7:0] REG_CLAMP_DUR  = 8'h11;
  localparam logic [7:0] REG_SLICE_THR  = 8'h12;
  localparam logic [7:0] REG_STATUS     = 8'h13;

  // field positions
  localparam int HS_POL_BIT    = 6;
  localparam int CLAMP_EXT_BIT = 7;
  localparam int CLAMP_POL_BIT = 6;
  localparam int ST_HSYNC_BIT  = 0;
  localparam int ST_CLAMP_BIT  = 1;
  localparam int ST_INT_BIT    = 2;

  // reset values
  localparam logic             HS_POL_RST    = 1'b1;
  localparam logic             CLAMP_EXT_RST = 1'b0;
  localparam logic             CLAMP_POL_RST = 1'b1;
  localparam logic [CNT_W-1:0] CLAMP_DLY_RST = 8'h08;
  localparam logic [CNT_W-1:0] CLAMP_DUR_RST = 8'h14;
  // threshold code is millivolts divided by ten
  localparam logic [THR_W-1:0] THR_RST = 6'h0F;
  localparam logic [THR_W-1:0] THR_MIN = 6'h01;
  localparam logic [THR_W-1:0] THR_MAX = 6'h21;

  // gray-coded walk: idle, wait out delay, clamp
  typedef enum logic [1:0] {
    SEC_IDLE  = 2'b00,
    SEC_WAIT  = 2'b01,
    SEC_CLAMP = 2'b11
  } sec_state_t;

  typedef struct packed {
    logic             hs_pol;
    logic             clamp_ext;
    logic             clamp_pol;
    logic [CNT_W-1:0] clamp_dly;
    logic [CNT_W-1:0] clamp_dur;
    logic [THR_W-1:0] thr;
  } sec_cfg_t;

endpackage

// >>> core/sec_sync.sv
// sec_sync: three-stage synchroniser with agreement filter for a pin.
// assumes the pin is asynchronous to mclk_in; output moves only once
// the second and third stages agree.
module sec_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic mclk_in,
  input  wire logic rst_in,
  input  wire logic ce_in,
  input  wire logic pin_in,
  output logic      level_out
);

  logic s1, s2, s3;
  logic next_level;

  // the filter looks only at the second and third stages
  always_comb begin
    next_level = level_out;
    if (s2 == s3) begin
      next_level = s3;
    end
  end

  // stage chain; first stage feeds only the second
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      s1        <= 1'b0;
      s2        <= 1'b0;
      s3        <= 1'b0;
      level_out <= RST_VAL;
    end else if (ce_in) begin
      s1        <= pin_in;
      s2        <= s1;
      s3        <= s2;
      level_out <= next_level;
    end
  end

endmodule

// >>> core/sec_clamp_gen.sv
// sec_clamp_gen: internal clamp window, a delay then a duration counted
// in pixel clocks from a start pulse.
// assumes start_in is a one-cycle pulse on the trailing hsync edge.
module sec_clamp_gen #(
  parameter int CNT_W = sec_pkg::CNT_W
) (
  input  wire logic             mclk_in,
  input  wire logic             rst_in,
  input  wire logic             ce_in,
  input  wire logic             start_in,
  input  wire logic [CNT_W-1:0] dly_in,
  input  wire logic [CNT_W-1:0] dur_in,
  output logic                  active_out,
  output sec_pkg::sec_state_t   state_out
);

  // refused at elaboration; the down-counters assume this span
  if (CNT_W < 1 || CNT_W > 16) begin : g_cnt_w_check
    $error("sec_clamp_gen: CNT_W out of range");
  end

  sec_pkg::sec_state_t state, next_state;
  logic [CNT_W-1:0]    cnt, next_cnt;

  // next state; a new start always wins over the walk in progress
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    // R11: restart each line
    if (start_in) begin
      if (dly_in != '0) begin
        next_state = sec_pkg::SEC_WAIT;
        next_cnt   = dly_in - 1'b1;
      end else if (dur_in != '0) begin
        next_state = sec_pkg::SEC_CLAMP;
        next_cnt   = dur_in - 1'b1;
      end else begin
        next_state = sec_pkg::SEC_IDLE;
      end
    end else begin
      case (state)
        // R4: delay then duration
        sec_pkg::SEC_WAIT: begin
          if (cnt != '0) begin
            next_cnt = cnt - 1'b1;
          end else if (dur_in != '0) begin
            next_state = sec_pkg::SEC_CLAMP;
            next_cnt   = dur_in - 1'b1;
          end else begin
            next_state = sec_pkg::SEC_IDLE;
          end
        end
        sec_pkg::SEC_CLAMP: begin
          if (cnt != '0) begin
            next_cnt = cnt - 1'b1;
          end else begin
            next_state = sec_pkg::SEC_IDLE;
          end
        end
        sec_pkg::SEC_IDLE: begin
          next_cnt = '0;
        end
        default: begin
          next_state = sec_pkg::SEC_IDLE;
          next_cnt   = '0;
        end
      endcase
    end
  end

  // register the walk
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state <= sec_pkg::SEC_IDLE;
      cnt   <= '0;
    end else if (ce_in) begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  assign active_out = (state == sec_pkg::SEC_CLAMP);
  assign state_out  = state;

endmodule

// >>> sim/sec_src_model.sv
// sec_src_model: video source driving the hsync and external clamp pins.
// assumes the bench raises run_in at a line boundary; pins only move
// just after a rising edge, as a source timed on the pixel clock would.
module sec_src_model #(
  parameter int LINE = 60,
  parameter int SW   = 12,
  parameter int CD   = 3,
  parameter int CW   = 6
) (
  input  wire logic mclk_in,
  input  wire logic rst_in,
  input  wire logic run_in,
  input  wire logic hs_pol_in,
  input  wire logic cl_use_in,
  input  wire logic cl_pol_in,
  output logic      hsync_out,
  output logic      clamp_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int   ph;
  logic bp;

  // back porch, where black level sits on the video inputs
  assign bp = run_in && ph >= SW + CD && ph < SW + CD + CW;

  // line phase, parked at zero between bursts
  always_ff @(posedge mclk_in) begin
    if (rst_in || !run_in)
      ph <= 0;
    else
      ph <= (ph == LINE - 1) ? 0 : ph + 1;
  end

  always_ff @(posedge mclk_in) begin
    hsync_out <= (run_in && ph < SW) ? hs_pol_in : !hs_pol_in;
    clamp_out <= cl_use_in ? (bp ? cl_pol_in : !cl_pol_in) : 1'b0;
  end
endmodule

// >>> sim/sec_top_tb_top.sv
// sec_top_tb_top: register, sync edge, clamp and slicer tests.
// assumes sec_src_model stands for the source; slicer pin driven here.
module sec_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LINE = 60;
  logic       mclk_in = 0, rst_in = 1, ce = 1, run = 0, slc = 0;
  logic       hpol = 1, use_cl = 0, cpol = 1, wr = 0, rd = 0;
  logic [7:0] addr = 0, wdata = 0, rdata;
  logic       hs_pin, cl_pin, href, clo, slo, hs_q = 0, cl_q = 0;
  logic [5:0] thr;
  logic [7:0] tw[6] = '{8'h01, 8'h21, 8'h00, 8'h22, 8'h0F, 8'h45};
  logic [7:0] te[6] = '{8'h01, 8'h21, 8'h21, 8'h21, 8'h0F, 8'h0F};
  logic [7:0] dl[2] = '{8'h05, 8'h00};
  logic [7:0] du[2] = '{8'h09, 8'h01};
  int         fails = 0, checked = 0, cyc = 0, nref, npul;
  int         run_len, ref_dly, cl_st, lead_c, trail_c;

  always #25 mclk_in = ~mclk_in;

  sec_top uut (
    .mclk_in(mclk_in), .rst_in(rst_in), .ce_in(ce), .hsync_in(hs_pin),
    .clamp_in(cl_pin), .embedded_sync_slicer_input_in(slc),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
    .rdata_out(rdata), .hsync_ref_out(href), .clamp_out(clo),
    .slicer_thr_out(thr), .embedded_sync_slicer_output_out(slo)
  );

  sec_src_model src (
    .mclk_in(mclk_in), .rst_in(rst_in), .run_in(run), .hs_pol_in(hpol),
    .cl_use_in(use_cl), .cl_pol_in(cpol), .hsync_out(hs_pin),
    .clamp_out(cl_pin)
  );

  task finish_test();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // pin edges, pulse counts and widths; a hang ends at the cycle ceiling
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      finish_test();
    end
    if (hs_pin !== hs_q) begin
      if (hs_pin === hpol) lead_c = cyc;
      else trail_c = cyc;
    end
    hs_q = hs_pin;
    if (href === 1'b1) begin
      nref++;
      ref_dly = cyc - lead_c;
    end
    if (clo === 1'b1 && cl_q !== 1'b1) begin
      npul++;
      run_len = 0;
      cl_st = cyc - trail_c;
    end
    if (clo === 1'b1) run_len++;
    cl_q = clo;
  end

  task tick(input int n);
    repeat (n) @(posedge mclk_in);
  endtask

  task chk(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t ns: got %h expected %h", $time, g, e);
    end
  endtask

  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk_in);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk_in);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask

  // whole lines from the source; counters cleared after settling
  task lines(input int n);
    tick(20);
    nref = 0;
    npul = 0;
    run <= 1'b1;
    tick(n * LINE);
    run <= 1'b0;
    tick(20);
  endtask

  initial begin
    tick(10);
    rst_in <= 1'b0;
    rd_chk(sec_pkg::REG_HSYNC_CTRL, 8'h40);
    rd_chk(sec_pkg::REG_CLAMP_CTRL, 8'h40);
    rd_chk(sec_pkg::REG_CLAMP_DLY, 8'h08);
    rd_chk(sec_pkg::REG_CLAMP_DUR, 8'h14);
    rd_chk(sec_pkg::REG_SLICE_THR, 8'h0F);
    chk({2'b00, thr}, 8'h0F);
    wr_reg(8'h20, 8'hFF);
    rd_chk(8'h20, 8'h00);
    // threshold ends kept, codes outside 10..330 mV refused
    foreach (tw[i]) begin
      wr_reg(sec_pkg::REG_SLICE_THR, tw[i]);
      rd_chk(sec_pkg::REG_SLICE_THR, te[i]);
      chk({2'b00, thr}, te[i]);
    end
    // a write while the clock enable is low must be lost
    tick(1);
    ce <= 1'b0;
    wr_reg(sec_pkg::REG_SLICE_THR, 8'h05);
    ce <= 1'b1;
    rd_chk(sec_pkg::REG_SLICE_THR, 8'h0F);
    chk({2'b00, thr}, 8'h0F);
    $display("test registers done");
    tick(1);
    for (int v = 0; v < 2; v++) begin
      slc <= v[0];
      tick(8);
      chk({7'h00, slo}, {7'h00, v[0]});
    end
    $display("test slicer done");
    // leading edge of either sense gives one pulse per line
    for (int p = 0; p < 2; p++) begin
      hpol <= p[0];
      wr_reg(sec_pkg::REG_HSYNC_CTRL, {1'b0, p[0], 6'h00});
      lines(3);
      chk(nref[7:0], 8'h03);
      chk({7'h00, ref_dly inside {[2:7]}}, 8'h01);
      // idle pin sits at the inactive level, seen in the status word
      rd_chk(sec_pkg::REG_STATUS, {7'h00, !p[0]});
    end
    $display("test hsync edge done");
    // pin pulses 6 wide here, so its influence would show in the width
    hpol <= 1'b1;
    use_cl <= 1'b1;
    wr_reg(sec_pkg::REG_HSYNC_CTRL, 8'h40);
    for (int k = 0; k < 2; k++) begin
      wr_reg(sec_pkg::REG_CLAMP_DLY, dl[k]);
      wr_reg(sec_pkg::REG_CLAMP_DUR, du[k]);
      lines(3);
      chk(npul[7:0], 8'h03);
      chk(run_len[7:0], du[k]);
      chk({7'h00, (cl_st - dl[k]) inside {[4:9]}}, 8'h01);
    end
    $display("test internal clamp done");
    for (int p = 0; p < 2; p++) begin
      cpol <= p[0];
      wr_reg(sec_pkg::REG_CLAMP_CTRL, {1'b1, p[0], 6'h00});
      rd_chk(sec_pkg::REG_CLAMP_CTRL, {1'b1, p[0], 6'h00});
      lines(3);
      chk(npul[7:0], 8'h03);
      chk(run_len[7:0], 8'h06);
    end
    $display("test external clamp done");
    finish_test();
  end
endmodule
